/* mti_entry_match.sv */
// Address comparator for one static table entry.
`timescale 1ns/1ps
module mti_entry_match
  import mti_pkg::*;
(
  // Entry and key
  input  wire mti_entry_t        entry_in,
  input  wire logic [47:0]       addr_in,
  input  wire logic [FID_W-1:0]  fid_in,
  input  wire logic [STG_W-1:0]  stg_in,
  // Result
  output logic                   hit_out
);
  logic fid_ok;

  assign fid_ok = !(addr_in[MAC_MCAST_BIT] && entry_in.mgm) || (entry_in.filter_group_id == fid_in);
  assign hit_out = entry_in.valid && (entry_in.mac == addr_in) && (entry_in.stg == stg_in) && fid_ok;
endmodule : mti_entry_match

/* mti_host_model.sv */
// Host processor model that reaches the table through the switch register port.
`timescale 1ns/1ps
module mti_host_model
  import mti_pkg::*;
(
  // Clock
  input  wire logic        clk_sys_in,
  // Register port
  output logic [AW-1:0]    reg_addr_out,
  output logic             reg_wr_out,
  output logic             reg_rd_out,
  output logic [31:0]      reg_wdata_out,
  input  wire logic [31:0] reg_rdata_in,
  input  wire logic        reg_rvalid_in
);
  initial begin
    reg_addr_out = '0;
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    reg_wdata_out = '0;
  end

  // ********************
  // Bus cycles
  // ********************
  task automatic wr32(input logic [AW-1:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    reg_addr_out <= a;
    reg_wdata_out <= d;
    reg_wr_out <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr_out <= 1'b0;
    // Stale data is inverted so nothing can lean on a held value.
    reg_wdata_out <= ~d;
  endtask : wr32

  task automatic rd32(input logic [AW-1:0] a, output logic [31:0] d);
    @(posedge clk_sys_in);
    reg_addr_out <= a;
    reg_rd_out <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd_out <= 1'b0;
    @(posedge clk_sys_in);
    d = reg_rvalid_in ? reg_rdata_in : 32'hdead_beef;
  endtask : rd32

  // ********************
  // Table commands
  // ********************
  task automatic cmd(input logic [31:0] c, output logic [31:0] v);
    int n;
    wr32(OFS_CTRL, c);
    n = 0;
    v = c;
    while (v[CTL_GO_BIT] !== 1'b0 && n < 8) begin
      rd32(OFS_CTRL, v);
      n++;
    end
  endtask : cmd

  task automatic st_write(input logic [3:0] i, input logic [31:0] a, b, c, d, output logic [31:0] v);
    wr32(OFS_W1, a);
    wr32(OFS_W2, b);
    wr32(OFS_W3, c);
    wr32(OFS_W4, d);
    cmd({23'h0, 1'b1, TBL_STATIC, ACT_WRITE, 2'h0, i}, v);
  endtask : st_write

  task automatic rmc_write(input logic [5:0] i, input logic [2:0] p, output logic [31:0] v);
    wr32(OFS_W2, {29'h0, p});
    cmd({23'h0, 1'b1, TBL_RMC, ACT_WRITE, i}, v);
  endtask : rmc_write

  task automatic tbl_read(input logic t, input logic [5:0] i, output logic [31:0] v);
    cmd({23'h0, 1'b1, t, ACT_READ, i}, v);
  endtask : tbl_read
endmodule : mti_host_model

/* mti_pkg.sv */
// Constants, types and helpers for the MAC table indirect access block.
// *********************************************************************
// What this block does
// - Entry override flag lets forwarding ignore blocked destination port state.
// - Second word bits 2..0 select ports 3, 2, 1 as destinations.
// - Third word holds filter group id and MAC high; fourth holds MAC low.
// - Static table holds 16 host-programmed entries that never age.
// - Every destination lookup consults all tables before deciding.
// - A static hit from either table beats any dynamic hit.
// - Static read: host writes index, read, go; device returns entry in words.
// - Device clears go_done itself when the access completes.
// - Table choice 0 is the static table, 1 the reserved multicast table.
// - First word bit 31 marks an entry valid; invalid entries never match.
// - First word bit 30 drops packets whose source address matches.
// - First word bit 29 drops packets whose destination address matches.
// - First word holds priority in 28:26 and spanning tree group in 2:0.
// - Second word bit 30 adds filter group id to multicast matching.
// - Reserved multicast table covers 48 addresses indexed by low 6 bits.
// - 48 addresses form 8 groups; writing one entry changes its whole group.
// - Reserved multicast accesses share the registers; only word two carries data.
// - Reserved multicast read returns the port map in word two.
// *********************************************************************
package mti_pkg;
  localparam int unsigned AW = 12;
  localparam logic [AW-1:0] OFS_CTRL = 12'h41c;
  localparam logic [AW-1:0] OFS_W1 = 12'h420;
  localparam logic [AW-1:0] OFS_W2 = 12'h424;
  localparam logic [AW-1:0] OFS_W3 = 12'h428;
  localparam logic [AW-1:0] OFS_W4 = 12'h42c;
  localparam int CTL_IDX_W = 6;
  localparam int CTL_ACT_BIT = 6;
  localparam int CTL_TBL_BIT = 7;
  localparam int CTL_GO_BIT = 8;
  localparam int W1_VALID = 31;
  localparam int W1_SRC_DROP = 30;
  localparam int W1_DST_DROP = 29;
  localparam int W1_PRIO_LSB = 26;
  localparam int PRIO_W = 3;
  localparam int STG_W = 3;
  localparam int W2_OVR = 31;
  localparam int W2_MGM = 30;
  localparam int PORTS_W = 3;
  localparam int W3_FID_LSB = 16;
  localparam int FID_W = 7;
  localparam int MAC_HI_W = 16;
  localparam logic [31:0] W1_MASK = 32'hfc00_0007;
  localparam logic [31:0] W2_MASK = 32'hc000_0007;
  localparam logic [31:0] W3_MASK = 32'h007f_ffff;
  localparam int ST_ENTRIES = 16;
  localparam int ST_IDX_W = 4;
  localparam logic [CTL_IDX_W-1:0] RMC_ENTRIES = 6'h30;
  localparam int RMC_GROUPS = 8;
  localparam logic [CTL_IDX_W-1:0] RMC_PER_GROUP = 6'h06;
  localparam int MAC_MCAST_BIT = 40;
  localparam logic TBL_STATIC = 1'b0;
  localparam logic TBL_RMC = 1'b1;
  localparam logic ACT_WRITE = 1'b0;
  localparam logic ACT_READ = 1'b1;

  typedef struct packed {
    logic               valid;
    logic               src_drop;
    logic               dst_drop;
    logic [PRIO_W-1:0]  prio;
    logic [STG_W-1:0]   stg;
    logic               ovr;
    logic               mgm;
    logic [PORTS_W-1:0] ports;
    logic [FID_W-1:0]   filter_group_id;
    logic [47:0]        mac;
  } mti_entry_t;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_ACCESS = 2'b01
  } mti_state_t;

  // Six consecutive indices share one forwarding map.
  function automatic logic [2:0] rmc_group(input logic [CTL_IDX_W-1:0] idx);
    logic [CTL_IDX_W-1:0] g;
    g = idx / RMC_PER_GROUP;
    return g[2:0];
  endfunction : rmc_group
endpackage : mti_pkg

/* mti_rmc_map.sv */
// Grouped forwarding maps of the reserved multicast table.
`timescale 1ns/1ps
module mti_rmc_map
  import mti_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk_sys_in,
  input  wire logic                  rst_in,
  // Host access
  input  wire logic                  wr_in,
  input  wire logic [CTL_IDX_W-1:0]  idx_in,
  input  wire logic [PORTS_W-1:0]    ports_in,
  output logic [PORTS_W-1:0]         rd_ports_out,
  // Lookup
  input  wire logic [CTL_IDX_W-1:0]  lk_idx_in,
  output logic [PORTS_W-1:0]         lk_ports_out
);
  logic [PORTS_W-1:0] map_r [RMC_GROUPS];

  // One map per group, so a write reaches every member address.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      for (int i = 0; i < RMC_GROUPS; i++) begin
        map_r[i] <= '0;
      end
    end else if (wr_in && idx_in < RMC_ENTRIES) begin
      map_r[rmc_group(idx_in)] <= ports_in;
    end
  end

  assign rd_ports_out = (idx_in < RMC_ENTRIES) ? map_r[rmc_group(idx_in)] : '0;
  assign lk_ports_out = map_r[rmc_group(lk_idx_in)];
endmodule : mti_rmc_map

/* mti_table_access.sv */
// Indirect access to the static and reserved multicast tables, plus lookup.
`timescale 1ns/1ps
module mti_table_access
  import mti_pkg::*;
#(
  parameter int          N_ST     = ST_ENTRIES,
  parameter logic [47:0] RMC_BASE = 48'h0100_0000_0000
)(
  // Clock and reset
  input  wire logic                clk_sys_in,
  input  wire logic                rst_in,
  // Register port
  input  wire logic [AW-1:0]       reg_addr_in,
  input  wire logic                reg_wr_in,
  input  wire logic                reg_rd_in,
  input  wire logic [31:0]         reg_wdata_in,
  output logic [31:0]              reg_rdata_out,
  output logic                     reg_rvalid_out,
  // Lookup request
  input  wire logic                lk_req_in,
  input  wire logic [47:0]         lk_da_in,
  input  wire logic [47:0]         lk_sa_in,
  input  wire logic [FID_W-1:0]    lk_fid_in,
  input  wire logic [STG_W-1:0]    lk_stg_in,
  input  wire logic [PORTS_W-1:0]  port_blocked_in,
  // Learned table result
  input  wire logic                dyn_hit_in,
  input  wire logic                dyn_static_in,
  input  wire logic [PORTS_W-1:0]  dyn_ports_in,
  input  wire logic                dyn_override_in,
  // Lookup result
  output logic                     lk_done_out,
  output logic                     lk_hit_out,
  output logic [PORTS_W-1:0]       lk_ports_out,
  output logic                     lk_override_out,
  output logic                     lk_drop_out,
  output logic                     lk_src_drop_out,
  output logic [PRIO_W-1:0]        lk_prio_out
);
  if (N_ST < 1 || N_ST > (1 << ST_IDX_W)) begin : g_chk
    $error("N_ST must be 1 to 16");
  end

  // *********************************************************************
  // Registers and storage
  // *********************************************************************
  mti_state_t          state_r;
  logic [CTL_IDX_W-1:0] ctl_idx_r;
  logic                ctl_act_r;
  logic                ctl_tbl_r;
  logic                ctl_go_r;
  logic [31:0]         w1_r;
  logic [31:0]         w2_r;
  logic [31:0]         w3_r;
  logic [31:0]         w4_r;
  mti_entry_t          st_mem_r [N_ST];
  mti_entry_t          wr_entry;
  mti_entry_t          rd_entry;
  logic                idx_ok;
  logic                do_st_wr;
  logic                do_st_rd;
  logic                do_rmc_wr;
  logic                do_rmc_rd;
  logic [PORTS_W-1:0]  rmc_rd_ports;
  logic [PORTS_W-1:0]  rmc_lk_ports;
  logic                host_wr;
  logic [31:0]         rdata_nxt;

  assign host_wr = reg_wr_in && (state_r == ST_IDLE);
  assign idx_ok = ctl_idx_r < CTL_IDX_W'(N_ST);
  assign do_st_wr = (state_r == ST_ACCESS) && ctl_tbl_r == TBL_STATIC && ctl_act_r == ACT_WRITE;
  assign do_st_rd = (state_r == ST_ACCESS) && ctl_tbl_r == TBL_STATIC && ctl_act_r == ACT_READ;
  assign do_rmc_wr = (state_r == ST_ACCESS) && ctl_tbl_r == TBL_RMC && ctl_act_r == ACT_WRITE;
  assign do_rmc_rd = (state_r == ST_ACCESS) && ctl_tbl_r == TBL_RMC && ctl_act_r == ACT_READ;
  assign rd_entry = idx_ok ? st_mem_r[ctl_idx_r[ST_IDX_W-1:0]] : '0;

  // *********************************************************************
  // Control register and access sequencer
  // *********************************************************************
  // Control writes are refused while an access runs, so go_done never races.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      state_r <= ST_IDLE;
      ctl_idx_r <= '0;
      ctl_act_r <= 1'b0;
      ctl_tbl_r <= 1'b0;
      ctl_go_r <= 1'b0;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (host_wr && reg_addr_in == OFS_CTRL) begin
            ctl_idx_r <= reg_wdata_in[CTL_IDX_W-1:0];
            ctl_act_r <= reg_wdata_in[CTL_ACT_BIT];
            ctl_tbl_r <= reg_wdata_in[CTL_TBL_BIT];
            ctl_go_r <= reg_wdata_in[CTL_GO_BIT];
            if (reg_wdata_in[CTL_GO_BIT]) begin
              state_r <= ST_ACCESS;
            end
          end
        end
        ST_ACCESS: begin
          ctl_go_r <= 1'b0;
          state_r <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // *********************************************************************
  // Shared data words
  // *********************************************************************
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      w1_r <= '0;
      w2_r <= '0;
      w3_r <= '0;
      w4_r <= '0;
    end else if (do_st_rd) begin
      w1_r <= '0;
      w1_r[W1_VALID] <= rd_entry.valid;
      w1_r[W1_SRC_DROP] <= rd_entry.src_drop;
      w1_r[W1_DST_DROP] <= rd_entry.dst_drop;
      w1_r[W1_PRIO_LSB +: PRIO_W] <= rd_entry.prio;
      w1_r[STG_W-1:0] <= rd_entry.stg;
      w2_r <= '0;
      w2_r[W2_OVR] <= rd_entry.ovr;
      w2_r[W2_MGM] <= rd_entry.mgm;
      w2_r[PORTS_W-1:0] <= rd_entry.ports;
      w3_r <= '0;
      w3_r[W3_FID_LSB +: FID_W] <= rd_entry.filter_group_id;
      w3_r[MAC_HI_W-1:0] <= rd_entry.mac[47:32];
      w4_r <= rd_entry.mac[31:0];
    end else if (do_rmc_rd) begin
      w2_r <= {{(32 - PORTS_W){1'b0}}, rmc_rd_ports};
    end else if (host_wr) begin
      unique case (reg_addr_in)
        OFS_W1: w1_r <= reg_wdata_in & W1_MASK;
        OFS_W2: w2_r <= reg_wdata_in & W2_MASK;
        OFS_W3: w3_r <= reg_wdata_in & W3_MASK;
        OFS_W4: w4_r <= reg_wdata_in;
        default: begin
        end
      endcase
    end
  end

  // *********************************************************************
  // Static table
  // *********************************************************************
  always_comb begin
    wr_entry = '0;
    wr_entry.valid = w1_r[W1_VALID];
    wr_entry.src_drop = w1_r[W1_SRC_DROP];
    wr_entry.dst_drop = w1_r[W1_DST_DROP];
    wr_entry.prio = w1_r[W1_PRIO_LSB +: PRIO_W];
    wr_entry.stg = w1_r[STG_W-1:0];
    wr_entry.ovr = w2_r[W2_OVR];
    wr_entry.mgm = w2_r[W2_MGM];
    wr_entry.ports = w2_r[PORTS_W-1:0];
    wr_entry.filter_group_id = w3_r[W3_FID_LSB +: FID_W];
    wr_entry.mac = {w3_r[MAC_HI_W-1:0], w4_r};
  end

  // Only host writes and reset change an entry; there is no aging path at all.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      for (int i = 0; i < N_ST; i++) begin
        st_mem_r[i] <= '0;
      end
    end else if (do_st_wr && idx_ok) begin
      st_mem_r[ctl_idx_r[ST_IDX_W-1:0]] <= wr_entry;
    end
  end

  mti_rmc_map u_rmc (
    .clk_sys_in   (clk_sys_in),
    .rst_in       (rst_in),
    .wr_in        (do_rmc_wr),
    .idx_in       (ctl_idx_r),
    .ports_in     (w2_r[PORTS_W-1:0]),
    .rd_ports_out (rmc_rd_ports),
    .lk_idx_in    (lk_da_in[CTL_IDX_W-1:0]),
    .lk_ports_out (rmc_lk_ports)
  );

  // *********************************************************************
  // Register read port
  // *********************************************************************
  always_comb begin
    unique case (reg_addr_in)
      OFS_CTRL: begin
        rdata_nxt = '0;
        rdata_nxt[CTL_IDX_W-1:0] = ctl_idx_r;
        rdata_nxt[CTL_ACT_BIT] = ctl_act_r;
        rdata_nxt[CTL_TBL_BIT] = ctl_tbl_r;
        rdata_nxt[CTL_GO_BIT] = ctl_go_r;
      end
      OFS_W1: rdata_nxt = w1_r;
      OFS_W2: rdata_nxt = w2_r;
      OFS_W3: rdata_nxt = w3_r;
      OFS_W4: rdata_nxt = w4_r;
      default: rdata_nxt = '0;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      reg_rdata_out <= '0;
      reg_rvalid_out <= 1'b0;
    end else begin
      reg_rvalid_out <= reg_rd_in;
      if (reg_rd_in) begin
        reg_rdata_out <= rdata_nxt;
      end
    end
  end

  // *********************************************************************
  // Destination and source lookup
  // *********************************************************************
  logic [N_ST-1:0]    da_hit;
  logic [N_ST-1:0]    sa_hit;
  mti_entry_t         st_sel;
  logic               st_any;
  logic               sa_drop;
  logic               rmc_match;
  logic               res_hit;
  logic [PORTS_W-1:0] res_ports;
  logic               res_ovr;
  logic               res_drop;
  logic [PRIO_W-1:0]  res_prio;

  for (genvar g = 0; g < N_ST; g++) begin : g_match
    mti_entry_match u_da (
      .entry_in (st_mem_r[g]),
      .addr_in  (lk_da_in),
      .fid_in   (lk_fid_in),
      .stg_in   (lk_stg_in),
      .hit_out  (da_hit[g])
    );
    mti_entry_match u_sa (
      .entry_in (st_mem_r[g]),
      .addr_in  (lk_sa_in),
      .fid_in   (lk_fid_in),
      .stg_in   (lk_stg_in),
      .hit_out  (sa_hit[g])
    );
  end

  // Lowest index wins when several static entries match.
  always_comb begin
    st_sel = '0;
    st_any = 1'b0;
    sa_drop = 1'b0;
    for (int i = N_ST - 1; i >= 0; i--) begin
      if (da_hit[i]) begin
        st_sel = st_mem_r[i];
        st_any = 1'b1;
      end
      if (sa_hit[i] && st_mem_r[i].src_drop) begin
        sa_drop = 1'b1;
      end
    end
  end

  assign rmc_match = (lk_da_in[47:CTL_IDX_W] == RMC_BASE[47:CTL_IDX_W])
                     && (lk_da_in[CTL_IDX_W-1:0] < RMC_ENTRIES);

  // All tables are weighed together; static results outrank dynamic ones.
  always_comb begin
    res_hit = 1'b1;
    res_ports = '0;
    res_ovr = 1'b0;
    res_drop = 1'b0;
    res_prio = '0;
    if (st_any) begin
      res_ports = st_sel.ports;
      res_ovr = st_sel.ovr;
      res_drop = st_sel.dst_drop;
      res_prio = st_sel.prio;
    end else if (dyn_hit_in && dyn_static_in) begin
      res_ports = dyn_ports_in;
      res_ovr = dyn_override_in;
    end else if (rmc_match) begin
      res_ports = rmc_lk_ports;
    end else if (dyn_hit_in) begin
      res_ports = dyn_ports_in;
      res_ovr = dyn_override_in;
    end else begin
      res_hit = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      lk_done_out <= 1'b0;
      lk_hit_out <= 1'b0;
      lk_ports_out <= '0;
      lk_override_out <= 1'b0;
      lk_drop_out <= 1'b0;
      lk_src_drop_out <= 1'b0;
      lk_prio_out <= '0;
    end else begin
      lk_done_out <= lk_req_in;
      if (lk_req_in) begin
        lk_hit_out <= res_hit;
        lk_ports_out <= res_ports & (~port_blocked_in | {PORTS_W{res_ovr}});
        lk_override_out <= res_ovr;
        lk_drop_out <= res_drop;
        lk_src_drop_out <= sa_drop;
        lk_prio_out <= res_prio;
      end
    end
  end

  // *********************************************************************
  // Assertions
  // *********************************************************************
  property p_go_clears;
    @(posedge clk_sys_in) disable iff (rst_in)
    $rose(ctl_go_r) |=> !ctl_go_r && state_r == ST_IDLE;
  endproperty
  a_go_clears: assert property (p_go_clears) else $error("go_done not cleared");

  property p_st_read;
    @(posedge clk_sys_in) disable iff (rst_in)
    do_st_rd |=> w4_r == $past(rd_entry.mac[31:0]) && w1_r[W1_VALID] == $past(rd_entry.valid);
  endproperty
  a_st_read: assert property (p_st_read) else $error("static read data wrong");

  property p_rmc_read;
    @(posedge clk_sys_in) disable iff (rst_in)
    do_rmc_rd |=> w2_r[PORTS_W-1:0] == $past(rmc_rd_ports) && w2_r[31:PORTS_W] == '0;
  endproperty
  a_rmc_read: assert property (p_rmc_read) else $error("multicast read data wrong");

  property p_block;
    @(posedge clk_sys_in) disable iff (rst_in)
    lk_req_in ##1 !lk_override_out |-> (lk_ports_out & $past(port_blocked_in)) == '0;
  endproperty
  a_block: assert property (p_block) else $error("blocked port forwarded");

  property p_static_wins;
    @(posedge clk_sys_in) disable iff (rst_in)
    lk_req_in && st_any && dyn_hit_in |=> lk_prio_out == $past(st_sel.prio) && lk_drop_out == $past(st_sel.dst_drop);
  endproperty
  a_static_wins: assert property (p_static_wins) else $error("dynamic beat static");

  property p_src_drop;
    @(posedge clk_sys_in) disable iff (rst_in)
    lk_req_in |=> lk_src_drop_out == $past(sa_drop);
  endproperty
  a_src_drop: assert property (p_src_drop) else $error("source drop wrong");

  property p_done;
    @(posedge clk_sys_in) disable iff (rst_in)
    lk_req_in |=> lk_done_out ##1 (lk_done_out == $past(lk_req_in));
  endproperty
  a_done: assert property (p_done) else $error("lookup result missing");

  property p_reserved;
    @(posedge clk_sys_in) disable iff (rst_in)
    (w1_r & ~W1_MASK) == '0 && (w2_r & ~W2_MASK) == '0 && (w3_r & ~W3_MASK) == '0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set");

  property p_st_write;
    @(posedge clk_sys_in) disable iff (rst_in)
    do_st_wr && idx_ok ##1 !do_st_wr |-> rd_entry == $past(wr_entry) || ctl_idx_r != $past(ctl_idx_r);
  endproperty
  a_st_write: assert property (p_st_write) else $error("static write lost");

  c_st_write: cover property (@(posedge clk_sys_in) disable iff (rst_in) do_st_wr);
  c_st_read: cover property (@(posedge clk_sys_in) disable iff (rst_in) do_st_rd);
  c_rmc_write: cover property (@(posedge clk_sys_in) disable iff (rst_in) do_rmc_wr);
  c_static_hit: cover property (@(posedge clk_sys_in) disable iff (rst_in) lk_req_in && st_any && dyn_hit_in);
endmodule : mti_table_access

/* tb_mti_table_access.sv */
// Self-checking bench for the MAC table indirect access block.
`timescale 1ns/1ps
module tb_mti_table_access import mti_pkg::*;;
  localparam logic [47:0] RMC_B = 48'h0180_c200_0000;
  typedef struct packed {
    logic [3:0]  idx;
    logic [31:0] w1, w2, w3, w4;
    logic [2:0]  blk;
    logic        hit;
    logic [2:0]  ports;
  } mti_row_t;
  mti_row_t rows [4] = '{
    '{4'h0, 32'h9400_0102, 32'h8000_0f05, 32'hff92_aabb, 32'h1122_3344, 3'h1, 1'b1, 3'h5},
    '{4'hf, 32'h8000_0001, 32'h0000_0006, 32'h0000_0102, 32'h0a0b_0c0d, 3'h2, 1'b1, 3'h4},
    '{4'h7, 32'h2000_0000, 32'h0000_0007, 32'h0000_0203, 32'h0000_0001, 3'h0, 1'b0, 3'h0},
    '{4'h2, 32'h8000_0000, 32'h4000_0003, 32'h0005_0103, 32'h0000_0001, 3'h0, 1'b1, 3'h3}};
  logic clk_sys_in, rst_in, reg_wr, reg_rd, reg_rvalid, lk_req, dh, ds, dov;
  logic done, hit, ovr, drop, sdrop;
  logic [AW-1:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, v;
  logic [47:0] da, sa;
  logic [6:0] filter_group_id;
  logic [2:0] stg, blk, dp, ports, prio;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;

  mti_table_access #(.N_ST(16), .RMC_BASE(RMC_B)) i_dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .reg_addr_in(reg_addr), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_wdata_in(reg_wdata),
    .reg_rdata_out(reg_rdata), .reg_rvalid_out(reg_rvalid), .lk_req_in(lk_req), .lk_da_in(da),
    .lk_sa_in(sa), .lk_fid_in(filter_group_id), .lk_stg_in(stg), .port_blocked_in(blk), .dyn_hit_in(dh),
    .dyn_static_in(ds), .dyn_ports_in(dp), .dyn_override_in(dov), .lk_done_out(done), .lk_hit_out(hit),
    .lk_ports_out(ports), .lk_override_out(ovr), .lk_drop_out(drop), .lk_src_drop_out(sdrop),
    .lk_prio_out(prio));
  mti_host_model i_host (.clk_sys_in(clk_sys_in), .reg_addr_out(reg_addr), .reg_wr_out(reg_wr),
    .reg_rd_out(reg_rd), .reg_wdata_out(reg_wdata), .reg_rdata_in(reg_rdata), .reg_rvalid_in(reg_rvalid));

  initial begin
    clk_sys_in = 1'b0;
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end

  // ********************
  // Checking and closing
  // ********************
  task automatic check(input string nm, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up

  // A run of a few hundred cycles is expected; the ceiling leaves wide margin.
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      wrap_up();
    end
  end

  task automatic lookup(input logic [47:0] d, s, input logic [6:0] f, input logic [2:0] g, b,
                        input logic h, t, input logic [2:0] p);
    @(posedge clk_sys_in);
    lk_req <= 1'b1;
    da <= d;
    sa <= s;
    filter_group_id <= f;
    stg <= g;
    blk <= b;
    dh <= h;
    ds <= t;
    dp <= p;
    @(posedge clk_sys_in);
    lk_req <= 1'b0;
    #1;
    check("lk_done", {31'h0, done}, 32'h1);
  endtask : lookup

  // ********************
  // Main sequence
  // ********************
  initial begin
    rst_in = 1'b1;
    {lk_req, dh, ds, dov} = '0;
    {da, sa, filter_group_id, stg, blk, dp} = '0;
    repeat (3) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    for (int a = 0; a < 5; a++) begin
      i_host.rd32(OFS_CTRL + AW'(4 * a), v);
      check("reset_word", v, 32'h0);
    end
    i_host.rd32(12'h400, v);
    check("unmapped", v, 32'h0);
    $display("test reset done");
    foreach (rows[i]) begin
      i_host.st_write(rows[i].idx, rows[i].w1, rows[i].w2, rows[i].w3, rows[i].w4, v);
      check("go_done", {31'h0, v[CTL_GO_BIT]}, 32'h0);
      lookup({rows[i].w3[15:0], rows[i].w4}, 48'h0, rows[i].w3[22:16], rows[i].w1[2:0], rows[i].blk, 1'b0, 1'b0, 3'h0);
      check("lk_hit", {31'h0, hit}, {31'h0, rows[i].hit});
      check("lk_ports", {29'h0, ports}, {29'h0, rows[i].ports});
      check("lk_drop", {31'h0, drop}, 32'h0);
      check("lk_ovr", {31'h0, ovr}, {31'h0, rows[i].hit & rows[i].w2[31]});
      if (rows[i].hit) check("lk_prio", {29'h0, prio}, {29'h0, rows[i].w1[28:26]});
    end
    foreach (rows[i]) begin
      i_host.tbl_read(TBL_STATIC, {2'h0, rows[i].idx}, v);
      i_host.rd32(OFS_W1, v);
      check("word1", v, rows[i].w1 & W1_MASK);
      i_host.rd32(OFS_W2, v);
      check("word2", v, rows[i].w2 & W2_MASK);
      i_host.rd32(OFS_W3, v);
      check("word3", v, rows[i].w3 & W3_MASK);
      i_host.rd32(OFS_W4, v);
      check("word4", v, rows[i].w4);
    end
    $display("test static_rows done");
    // Entry with multicast group match set must miss when the filter group differs.
    lookup(48'h0103_0000_0001, 48'h0, 7'h06, 3'h0, 3'h0, 1'b0, 1'b0, 3'h0);
    check("fid_miss", {31'h0, hit}, 32'h0);
    lookup(48'haabb_1122_3344, 48'h0, 7'h12, 3'h3, 3'h0, 1'b0, 1'b0, 3'h0);
    check("stg_miss", {31'h0, hit}, 32'h0);
    lookup(48'h0102_0a0b_0c0d, 48'h0, 7'h01, 3'h1, 3'h0, 1'b1, 1'b0, 3'h1);
    check("static_wins", {29'h0, ports}, 32'h6);
    lookup(48'h0000_0000_0042, 48'h0, 7'h0, 3'h0, 3'h0, 1'b1, 1'b0, 3'h1);
    check("dyn_hit", {28'h0, hit, ports}, 32'h9);
    @(posedge clk_sys_in);
    dov <= 1'b1;
    lookup(48'h0000_0000_0042, 48'h0, 7'h0, 3'h0, 3'h1, 1'b1, 1'b1, 3'h1);
    check("learned_ovr", {28'h0, ovr, ports}, 32'h9);
    i_host.st_write(4'h3, 32'he000_0000, 32'h0000_0001, 32'h0000_0005, 32'h0000_0006, v);
    lookup(48'h0005_0000_0006, 48'h0, 7'h0, 3'h0, 3'h0, 1'b0, 1'b0, 3'h0);
    check("dst_drop", {31'h0, drop}, 32'h1);
    lookup(48'h0000_0000_0000, 48'h0005_0000_0006, 7'h0, 3'h0, 3'h0, 1'b0, 1'b0, 3'h0);
    check("src_drop", {31'h0, sdrop}, 32'h1);
    $display("test precedence_drop done");
    i_host.rmc_write(6'h07, 3'h3, v);
    i_host.tbl_read(TBL_RMC, 6'h0b, v);
    i_host.rd32(OFS_W2, v);
    check("rmc_group", v, 32'h3);
    i_host.tbl_read(TBL_RMC, 6'h05, v);
    i_host.rd32(OFS_W2, v);
    check("rmc_other", v, 32'h0);
    i_host.tbl_read(TBL_STATIC, 6'h07, v);
    i_host.rd32(OFS_W2, v);
    check("static_kept", v, 32'h7);
    lookup({RMC_B[47:6], 6'h09}, 48'h0, 7'h0, 3'h0, 3'h0, 1'b0, 1'b0, 3'h0);
    check("rmc_lookup", {28'h0, hit, ports}, 32'hb);
    $display("test reserved_mcast done");
    // A reset in mid-run must empty the table and the data words again.
    @(posedge clk_sys_in);
    rst_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    lookup(48'haabb_1122_3344, 48'h0, 7'h12, 3'h2, 3'h0, 1'b0, 1'b0, 3'h0);
    check("reset_lookup", {28'h0, hit, ports}, 32'h0);
    i_host.rd32(OFS_W1, v);
    check("reset_word1", v, 32'h0);
    $display("test mid_reset done");
    wrap_up();
  end
endmodule : tb_mti_table_access
